// ==== core/eds_pkg.sv ====
`default_nettype none
package eds_pkg;
    // timer oscillator and derived periods
    localparam int TMR_HZ     = 32768;
    localparam int HB_HZ      = 2;
    localparam int HALF_TICKS = TMR_HZ / HB_HZ;
    localparam int GAP_US     = 62500;
    localparam int GAP_TICKS  = GAP_US * TMR_HZ / 1000000;
    localparam int STEP_MS    = 7500;
    localparam int STEP_HS    = STEP_MS * HB_HZ / 1000;
    localparam int CYCLE_S    = 60;
    localparam int CYCLE_HS   = CYCLE_S * HB_HZ;
    localparam int UNIT_H     = 2;
    localparam int UNIT_HS    = UNIT_H * 3600 * HB_HZ;
    localparam int WD_HS      = HB_HZ;
    // counter widths, cell count and odd/even group masks
    localparam int SUB_W  = 14;
    localparam int POS_W  = 7;
    localparam int UNIT_W = 14;
    localparam int REM_W  = 9;
    localparam int N_CELLS = 12;
    localparam logic [N_CELLS-1:0] ODD_MASK  = 12'h555;
    localparam logic [N_CELLS-1:0] EVEN_MASK = 12'hAAA;
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SWSEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_BALEN = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_WDOG  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_GPIO  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h14;
    // field positions
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_DUTY_LSB = 4;
    localparam int CTRL_TOUT_LSB = 8;
    localparam int WDOG_EN_BIT   = 4;
    localparam int STAT_HB_LSB   = 4;
    localparam int STAT_REM_LSB  = 8;
    localparam int STAT_WDB_BIT  = 17;
    typedef enum logic [1:0] {
        EDS_IDLE = 2'b00,
        EDS_ODD  = 2'b01,
        EDS_EVEN = 2'b10
    } eds_phase_t;
endpackage
`default_nettype wire

// ==== core/eds_tim_if.sv ====
`default_nettype none
interface eds_tim_if;
    import eds_pkg::*;
    logic             tick;
    logic             run;
    logic             half;
    logic [SUB_W-1:0] sub;
    modport gen  (output tick);
    modport pre  (input tick, input run, output half, output sub);
    modport core (input half, input sub, output run);
endinterface
`default_nettype wire

// ==== core/eds_tick_gen.sv ====
`default_nettype none
module eds_tick_gen
    import eds_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    input  wire logic  osc_in,
    eds_tim_if.gen     tim
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    // two-stage sync, then rising edge of the slow oscillator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= osc_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // all slow timing comes from this tick, not from clk
    assign tim.tick = ce && s2_q && !s3_q;
endmodule
`default_nettype wire

// ==== core/eds_prescale.sv ====
`default_nettype none
module eds_prescale
    import eds_pkg::*;
#(
    parameter int HALF = HALF_TICKS
)
(
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    eds_tim_if.pre     tim
);
    logic [SUB_W-1:0] sub_q;
    logic             half_q;
    logic             wrap;
    assign wrap = tim.tick && (sub_q == SUB_W'(HALF - 1));
    // half-second prescaler, restarts whenever run drops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sub_q  <= '0;
            half_q <= 1'b0;
        end else if (ce) begin
            half_q <= tim.run && wrap;
            if (!tim.run || wrap) begin
                sub_q <= '0;
            end else if (tim.tick) begin
                sub_q <= sub_q + 1'b1;
            end
        end
    end
    assign tim.half = half_q;
    assign tim.sub  = sub_q;
endmodule
`default_nettype wire

// ==== core/eds_seq.sv ====
// The APB interface to the registers and the register offsets were decided locally.
`default_nettype none
module eds_seq
    import eds_pkg::*;
#(
    parameter int HALF_P  = HALF_TICKS,
    parameter int GAP_P   = GAP_TICKS,
    parameter int STEP_P  = STEP_HS,
    parameter int CYCLE_P = CYCLE_HS,
    parameter int UNIT_P  = UNIT_HS
)
(
    input  wire logic                CLK,
    input  wire logic                RESETN,
    input  wire logic                CE,
    input  wire logic                OSC_32K,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    output logic      [N_CELLS-1:0]  BAL_SW,
    output logic                     TIMER_ACTIVE_PIN
);
    eds_tim_if tim ();

    eds_tick_gen u_tick (
        .clk    (CLK),
        .resetn (RESETN),
        .ce     (CE),
        .osc_in (OSC_32K),
        .tim    (tim)
    );

    eds_prescale #(.HALF(HALF_P)) u_pre (
        .clk    (CLK),
        .resetn (RESETN),
        .ce     (CE),
        .tim    (tim)
    );

    // software registers
    logic                emergency_discharge_enable_q;
    logic [2:0]          discharge_duty_field_q;
    logic [7:0]          discharge_timeout_field_q;
    logic [N_CELLS-1:0]  discharge_switch_select_q;
    logic [N_CELLS-1:0]  balance_switch_enable_q;
    logic [3:0]          balance_watchdog_count_q;
    logic                wd_en_q;
    logic                gpio_level_q;
    // sequencer state
    logic                act_q;
    eds_phase_t          st_q;
    logic [POS_W-1:0]    pos_q;
    logic [UNIT_W-1:0]   unit_q;
    logic [REM_W-1:0]    remain_q;
    logic [3:0]          discharge_heartbeat_counter_q;
    logic                wd_sec_q;
    // bus and outputs
    logic                pready_q;
    logic                pslverr_q;
    logic [31:0]         prdata_q;
    logic [31:0]         rd_d;
    logic                hit_d;
    logic [N_CELLS-1:0]  bal_sw_q;
    logic [N_CELLS-1:0]  bal_sw_d;
    logic                pin_q;
    // combinational helpers
    logic                act;
    logic                enter;
    logic                wr;
    logic                in_gap;
    logic                on_win;
    logic                unit_wrap;
    logic                expire;
    logic                wd_block;
    logic                wd_dec;
    logic [N_CELLS-1:0]  grp_mask;

    assign wr = PSEL && PENABLE && PWRITE && pready_q;
    // mode is live only with a nonzero timeout
    assign act   = emergency_discharge_enable_q
                   && (discharge_timeout_field_q != 8'h00);
    assign enter = act && !act_q;
    // the prescaler restarts on entry so cycles align to it
    assign tim.run = !enter && (act_q || (wd_en_q
                     && balance_watchdog_count_q != 4'h0));
    // last slice of every minute is forced off
    // half covers the clock where sub has wrapped but pos has not
    assign in_gap = (pos_q == POS_W'(CYCLE_P - 1))
                    && (tim.half || int'(tim.sub) >= HALF_P - GAP_P);
    // on-window opens each minute, length set by duty
    assign on_win = (int'(pos_q) < (int'(discharge_duty_field_q) + 1)
                    * STEP_P) && !in_gap;
    assign grp_mask = (st_q == EDS_ODD) ? ODD_MASK : EVEN_MASK;
    assign unit_wrap = act_q && tim.half
                       && (unit_q == UNIT_W'(UNIT_P - 1));
    assign expire = unit_wrap && (remain_q == REM_W'(1));
    // outside the active mode, an expired watchdog holds the switches off
    assign wd_block = wd_en_q && (balance_watchdog_count_q == 4'h0);
    assign wd_dec = !act_q && wd_en_q && tim.half && wd_sec_q
                    && (balance_watchdog_count_q != 4'h0);
    // switch source select, evaluated every cycle
    always_comb begin
        if (act_q) begin
            bal_sw_d = on_win ? (discharge_switch_select_q & grp_mask)
                              : '0;
        end else if (wd_block) begin
            bal_sw_d = '0;
        end else begin
            bal_sw_d = balance_switch_enable_q;
        end
    end

    // control register; hardware expiry drops the enable
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            emergency_discharge_enable_q <= 1'b0;
            discharge_duty_field_q       <= 3'h0;
            discharge_timeout_field_q    <= 8'h00;
        end else if (CE) begin
            if (wr && PADDR == OFF_CTRL) begin
                emergency_discharge_enable_q <= PWDATA[CTRL_EN_BIT];
                discharge_duty_field_q <=
                    PWDATA[CTRL_DUTY_LSB +: 3];
                discharge_timeout_field_q <=
                    PWDATA[CTRL_TOUT_LSB +: 8];
            end else if (expire) begin
                emergency_discharge_enable_q <= 1'b0;
            end
        end
    end

    // switch maps and pin level
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            discharge_switch_select_q <= '0;
            balance_switch_enable_q   <= '0;
            gpio_level_q              <= 1'b0;
        end else if (CE && wr) begin
            if (PADDR == OFF_SWSEL) begin
                discharge_switch_select_q <= PWDATA[N_CELLS-1:0];
            end
            if (PADDR == OFF_BALEN) begin
                balance_switch_enable_q <= PWDATA[N_CELLS-1:0];
            end
            if (PADDR == OFF_GPIO) begin
                gpio_level_q <= PWDATA[0];
            end
        end
    end

    // watchdog: entry clear beats a reload in the same cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            balance_watchdog_count_q <= 4'h0;
            wd_en_q                  <= 1'b0;
            wd_sec_q                 <= 1'b0;
        end else if (CE) begin
            if (tim.half) begin
                wd_sec_q <= !wd_sec_q;
            end
            if (enter) begin
                balance_watchdog_count_q <= 4'h0;
            end else if (wr && PADDR == OFF_WDOG) begin
                balance_watchdog_count_q <= PWDATA[3:0];
                wd_en_q <= PWDATA[WDOG_EN_BIT];
            end else if (wd_dec) begin
                balance_watchdog_count_q <=
                    balance_watchdog_count_q - 4'h1;
            end
        end
    end

    // odd/even alternation within the active mode
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            act_q <= 1'b0;
            st_q  <= EDS_IDLE;
            pos_q <= '0;
        end else if (CE) begin
            act_q <= act;
            if (!act) begin
                st_q  <= EDS_IDLE;
                pos_q <= '0;
            end else if (enter) begin
                st_q  <= EDS_ODD;
                pos_q <= '0;
            end else if (tim.half) begin
                if (pos_q == POS_W'(CYCLE_P - 1)) begin
                    pos_q <= '0;
                    unique case (st_q)
                        EDS_ODD:  st_q <= EDS_EVEN;
                        EDS_EVEN: st_q <= EDS_ODD;
                        default:  st_q <= EDS_ODD;
                    endcase
                end else begin
                    pos_q <= pos_q + 1'b1;
                end
            end
        end
    end

    // timeout countdown in two-hour units
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            unit_q   <= '0;
            remain_q <= '0;
        end else if (CE) begin
            if (!act) begin
                unit_q   <= '0;
                remain_q <= '0;
            end else if (enter) begin
                unit_q   <= '0;
                remain_q <= {1'b0, discharge_timeout_field_q}
                            + REM_W'(1);
            end else if (act_q && tim.half) begin
                if (unit_wrap) begin
                    unit_q   <= '0;
                    remain_q <= remain_q - REM_W'(1);
                end else begin
                    unit_q <= unit_q + 1'b1;
                end
            end
        end
    end

    // heartbeat keeps its value while the mode is off
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            discharge_heartbeat_counter_q <= 4'h0;
        end else if (CE && act_q && tim.half) begin
            discharge_heartbeat_counter_q <=
                discharge_heartbeat_counter_q + 4'h1;
        end
    end

    // registered outputs toward switches and pin
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            bal_sw_q <= '0;
            pin_q    <= 1'b0;
        end else if (CE) begin
            bal_sw_q <= bal_sw_d;
            pin_q    <= act_q ? 1'b1 : gpio_level_q;
        end
    end

    // read mux; unmapped addresses read zero with an error
    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b1;
        unique case (PADDR)
            OFF_CTRL: begin
                rd_d[CTRL_EN_BIT] = emergency_discharge_enable_q;
                rd_d[CTRL_DUTY_LSB +: 3] = discharge_duty_field_q;
                rd_d[CTRL_TOUT_LSB +: 8] = discharge_timeout_field_q;
            end
            OFF_SWSEL: rd_d[N_CELLS-1:0] = discharge_switch_select_q;
            OFF_BALEN: rd_d[N_CELLS-1:0] = balance_switch_enable_q;
            OFF_WDOG: begin
                rd_d[3:0] = balance_watchdog_count_q;
                rd_d[WDOG_EN_BIT] = wd_en_q;
            end
            OFF_GPIO: rd_d[0] = gpio_level_q;
            OFF_STAT: begin
                rd_d[0] = act_q;
                rd_d[1] = (st_q == EDS_ODD);
                rd_d[2] = act_q && on_win;
                rd_d[STAT_HB_LSB +: 4] = discharge_heartbeat_counter_q;
                rd_d[STAT_REM_LSB +: REM_W] = remain_q;
                rd_d[STAT_WDB_BIT] = wd_block;
            end
            default: hit_d = 1'b0;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (CE) begin
            pready_q <= PSEL && PENABLE && !pready_q;
            if (PSEL && PENABLE && !pready_q) begin
                pslverr_q <= !hit_d || (PWRITE && PADDR == OFF_STAT);
                prdata_q  <= PWRITE ? 32'h0000_0000 : rd_d;
            end else begin
                pslverr_q <= 1'b0;
                prdata_q  <= 32'h0000_0000;
            end
        end
    end

    assign PRDATA           = prdata_q;
    assign PREADY           = pready_q;
    assign PSLVERR          = pslverr_q;
    assign BAL_SW           = bal_sw_q;
    assign TIMER_ACTIVE_PIN = pin_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN || !CE);
    sequence s_ctrl_off;
        wr && PADDR == OFF_CTRL && !PWDATA[CTRL_EN_BIT];
    endsequence
    sequence s_entry;
        act && !act_q ##1 act_q;
    endsequence

    a_zero_tout_idle: assert property (
        discharge_timeout_field_q == 8'h00 |=> !act_q)
        else $error("mode active with zero timeout");
    a_entry_wd_clear: assert property (
        s_entry |-> balance_watchdog_count_q == 4'h0)
        else $error("watchdog count not cleared on entry");
    a_entry_odd_load: assert property (
        s_entry |-> st_q == EDS_ODD && pos_q == '0 && remain_q ==
        {1'b0, $past(discharge_timeout_field_q)} + REM_W'(1))
        else $error("entry did not start odd cycle with timeout");
    a_sw_follow_sel: assert property (
        act_q |=> (BAL_SW & ~$past(discharge_switch_select_q)) == '0)
        else $error("switch on outside discharge select");
    a_group_mask: assert property (
        act_q && st_q == EDS_ODD |=> (BAL_SW & EVEN_MASK) == '0)
        else $error("even switch on during odd cycle");
    a_gap_off: assert property (
        act_q && in_gap |=> BAL_SW == '0)
        else $error("switch on during end-of-cycle gap");
    a_pin_active: assert property (
        act_q |=> TIMER_ACTIVE_PIN)
        else $error("timer pin low while counting");
    a_heartbeat_step: assert property (
        act_q && tim.half |=> discharge_heartbeat_counter_q ==
        $past(discharge_heartbeat_counter_q) + 4'h1)
        else $error("heartbeat failed to step");
    a_clear_ends: assert property (
        s_ctrl_off |-> ##2 !act_q && remain_q == '0 ##1 !TIMER_ACTIVE_PIN
        || gpio_level_q)
        else $error("mode not ended by clearing enable");
    a_revert_sw: assert property (
        !act_q && !wd_block |=> BAL_SW == $past(balance_switch_enable_q))
        else $error("switches not back on balance enable");
    a_expire_ends: assert property (
        expire |=> !emergency_discharge_enable_q ##1 !act_q)
        else $error("timeout expiry did not end mode");
endmodule
`default_nettype wire

// ==== verification/eds_sw_model.sv ====
`default_nettype none
// timer oscillator and switch array as seen from the cells
module eds_sw_model
    import eds_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               mon_en,
    input  wire logic [N_CELLS-1:0] bal_sw,
    output logic                    osc,
    output logic      [7:0]         gap_cnt,
    output logic      [7:0]         gap_bad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0]         div_q  = 2'h0;
    logic               osc_q  = 1'b0;
    logic [7:0]         zrun_q = 8'h00;
    logic [7:0]         cnt_q  = 8'h00;
    logic [7:0]         bad_q  = 8'h00;
    logic [N_CELLS-1:0] last_q = '0;

    // one driver per output, counters start at zero
    assign osc     = osc_q;
    assign gap_cnt = cnt_q;
    assign gap_bad = bad_q;

    // free running oscillator, one period per 8 clocks
    always @(posedge clk) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3)
            osc_q <= ~osc_q;
    end

    // length of the current all-off run, saturating
    always @(posedge clk) begin
        if (bal_sw != '0)
            zrun_q <= 8'h00;
        else if (zrun_q != 8'hFF)
            zrun_q <= zrun_q + 8'h01;
    end

    // a group change must be preceded by the full off gap
    always @(posedge clk) begin
        if (bal_sw != '0) begin
            last_q <= bal_sw;
            if (mon_en && last_q != '0 && bal_sw != last_q) begin
                cnt_q <= cnt_q + 8'h01;
                if (zrun_q < 8'h0F)
                    bad_q <= bad_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/eds_seq_test.sv ====
`default_nettype none
module eds_seq_test
    import eds_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // one half second is 8 ticks of an 8-clock oscillator
    localparam int HS = 64;

    logic               clk = 1'b0;
    logic               resetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [ADDR_W-1:0]  paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [N_CELLS-1:0] bal_sw;
    logic               pin;
    logic               osc;
    logic               mon_en;
    logic               ce;
    logic               err_exp = 1'b0;
    logic [7:0]         gap_cnt;
    logic [7:0]         gap_bad;
    logic [31:0]        rd;
    logic [3:0]         hb;
    int                 err_count = 0;
    int                 n_tests = 0;
    int                 cyc = 0;
    int                 t0;

    always #4 clk = ~clk;

    // cycle count for timing samples within a run
    always @(posedge clk)
        cyc <= cyc + 1;

    eds_seq #(.HALF_P(8), .GAP_P(2), .STEP_P(2), .CYCLE_P(16), .UNIT_P(4))
    DUT (
        .CLK(clk), .RESETN(resetn), .CE(ce), .OSC_32K(osc),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BAL_SW(bal_sw), .TIMER_ACTIVE_PIN(pin)
    );

    eds_sw_model u_far (
        .clk(clk), .mon_en(mon_en), .bal_sw(bal_sw), .osc(osc),
        .gap_cnt(gap_cnt), .gap_bad(gap_bad)
    );

    task automatic close_out;
        $display("errors %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask

    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        rd = {prdata[31:1], prdata[0]};
        check(pslverr, err_exp);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 32)
            err_count++;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // middle of half second k after the run start
    task automatic at_hs(input int k);
        while (cyc < t0 + k * HS + HS / 2)
            @(posedge clk);
    endtask

    // hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out;
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        mon_en = 1'b0;
        ce = 1'b1;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        check(bal_sw, 0);
        check(pin, 0);
        apb(1'b0, OFF_STAT, 0);
        check(rd, 0);
        // status is read only and unmapped words answer an error
        err_exp = 1'b1;
        apb(1'b1, OFF_STAT, 32'h0000_0001);
        apb(1'b0, 8'h40, 0);
        err_exp = 1'b0;
        // normal balancing and pin under software
        apb(1'b1, OFF_BALEN, 32'h0000_0FFF);
        apb(1'b1, OFF_SWSEL, 32'h0000_0FFF);
        apb(1'b1, OFF_GPIO, 32'h0000_0001);
        settle(3);
        check(bal_sw, 12'hFFF);
        check(pin, 1'b1);
        // enable with zero timeout never enters the mode
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        settle(4);
        check(bal_sw, 12'hFFF);
        apb(1'b0, OFF_STAT, 0);
        check(rd[0], 1'b0);
        // expired watchdog blocks until reloaded
        apb(1'b1, OFF_CTRL, 0);
        apb(1'b1, OFF_WDOG, 32'h0000_0011);
        settle(5 * HS);
        check(bal_sw, 0);
        apb(1'b1, OFF_WDOG, 32'h0000_001F);
        settle(4);
        check(bal_sw, 12'hFFF);
        // run with duty 0 and timeout 5: 24 half seconds
        apb(1'b1, OFF_GPIO, 0);
        apb(1'b1, OFF_CTRL, 32'h0000_0501);
        t0 = cyc;
        at_hs(1);
        check(bal_sw, ODD_MASK);
        check(pin, 1'b1);
        apb(1'b0, OFF_STAT, 0);
        check(rd[0], 1'b1);
        check(rd[16:8], 9'd6);
        hb = rd[7:4];
        apb(1'b0, OFF_WDOG, 0);
        check(rd[3:0], 4'h0);
        at_hs(5);
        check(bal_sw, 0);
        apb(1'b0, OFF_STAT, 0);
        check(rd[7:4], 4'(hb + 4'h4));
        at_hs(17);
        check(bal_sw, EVEN_MASK);
        at_hs(23);
        apb(1'b0, OFF_STAT, 0);
        check(rd[0], 1'b1);
        at_hs(25);
        apb(1'b0, OFF_STAT, 0);
        check(rd[0], 1'b0);
        apb(1'b0, OFF_CTRL, 0);
        check(rd[0], 1'b0);
        check(bal_sw, 0);
        check(pin, 1'b0);
        apb(1'b1, OFF_WDOG, 0);
        settle(4);
        check(bal_sw, 12'hFFF);
        // full duty run, watched for the gap, then aborted
        apb(1'b1, OFF_CTRL, 32'h0000_0471);
        t0 = cyc;
        at_hs(1);
        check(bal_sw, ODD_MASK);
        mon_en <= 1'b1;
        at_hs(17);
        check(bal_sw, EVEN_MASK);
        check(gap_cnt, 8'h01);
        check(gap_bad, 8'h00);
        mon_en <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h0000_0470);
        settle(4);
        check(bal_sw, 12'hFFF);
        check(pin, 1'b0);
        // re-entry starts from a full timeout again
        apb(1'b1, OFF_CTRL, 32'h0000_0471);
        t0 = cyc;
        at_hs(1);
        apb(1'b0, OFF_STAT, 0);
        check(rd[16:8], 9'd5);
        // clock enable low freezes the whole sequencer
        hb = rd[7:4];
        ce <= 1'b0;
        settle(3 * HS);
        check(bal_sw, ODD_MASK);
        check(pin, 1'b1);
        ce <= 1'b1;
        apb(1'b0, OFF_STAT, 0);
        check(rd[7:4], hb);
        check(rd[16:8], 9'd5);
        apb(1'b1, OFF_CTRL, 0);
        close_out;
    end
endmodule
`default_nettype wire
